// [pol_pkg.sv]
// Package: constants, register map and carrier types of the pulse output block
package pol_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int CYCLE_4MS_US  = 4000;
  localparam int CYCLE_1MS_US  = 1000;
  localparam int CYC_4MS       = CYCLE_4MS_US * CLK_MHZ;
  localparam int CYC_1MS       = CYCLE_1MS_US * CLK_MHZ;
  localparam int HALF_PERIOD_ACC = CLK_HZ / 2;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NCH    = 4;
  localparam int FW     = 17;
  localparam int ACCW   = 27;
  localparam int ADRW   = 8;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_SETUP_PEND = 8'h00;
  localparam logic [7:0] REG_SETUP_ACT  = 8'h04;
  localparam logic [7:0] REG_SPEED_PEND = 8'h08;
  localparam logic [7:0] REG_SPEED_ACT  = 8'h0C;
  localparam logic [7:0] REG_ACCEL      = 8'h10;
  localparam logic [7:0] REG_GPOUT      = 8'h14;
  localparam logic [7:0] REG_PWM_DUTY   = 8'h18;
  localparam logic [2:0] REG_CH_REGION  = 3'h1;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CMD_START  = 0;
  localparam int CMD_STOP   = 1;
  localparam int CMD_SEARCH = 2;
  localparam int CMD_CCW    = 3;
  localparam int CMD_PDIR   = 4;
  localparam int FREQ_LSB   = 12;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] pwm_en;
    logic [1:0] pulse_en;
    logic       s_curve;
    logic       clr_origin;
    logic       lim_no;
    logic       lim_always;
    logic       cycle_1ms;
  } pol_cfg_type;

  localparam pol_cfg_type CFG_RESET = 11'h000;
  localparam logic [15:0] ACCEL_RESET = 16'h0001;

  typedef struct packed {
    logic            cyc;
    logic            stb;
    logic            we;
    logic [ADRW-1:0] adr;
    logic [3:0]      sel;
    logic [31:0]     dat;
  } pol_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pol_wb_rsp_type;

  typedef struct packed {
    logic [NCH-1:0] cw;
    logic [NCH-1:0] ccw;
    logic [NCH-1:0] origin;
  } pol_sense_type;

endpackage : pol_pkg

// [pol_pulse_out.sv]
// Pulse output channels with limit handling, setup adoption and terminal sharing
`timescale 1ns/100ps

// Operation
// - Control loop ticks every 4 ms or 1 ms, chosen by setup bit.
// - Search-only mode checks limit inputs only during an origin search.
// - Always mode applies limit inputs to every pulse output function too.
// - Limit polarity setting: NC active when open, NO active when closed.
// - Hold-origin: limit stops output, origin status and position kept.
// - Clear-origin: limit stops output and makes origin undefined.
// - Origin search starts at the configured initial speed; start commands begin at zero.
// - Ramps follow linear trapezoid or S-shape per speed-curve setting.
// - New pulse settings take effect only after the next power-up or restart.
// - First four terminals per module are general outputs or pulse outputs.
// - Fifth and sixth terminals per module are general or PWM, each alone.
// - The first channel's command in each module selects CW/CCW trains or pulse plus direction for both channels.
module pol_pulse_out #(
  parameter int TICK_4MS_CYCLES = pol_pkg::CYC_4MS,
  parameter int TICK_1MS_CYCLES = pol_pkg::CYC_1MS
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    power_restart,
  input  wire pol_pkg::pol_wb_req_type wb_req,
  output pol_pkg::pol_wb_rsp_type      wb_rsp,
  input  wire pol_pkg::pol_sense_type  sense,
  output logic [5:0]                   module0_terminals,
  output logic [5:0]                   module1_terminals
);
  import pol_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    pol_cfg_type               pend_cfg;
    pol_cfg_type               act_cfg;
    logic [FW-1:0]             pend_speed;
    logic [FW-1:0]             act_speed;
    logic                      adopt;
    logic [15:0]               accel;
    logic [11:0]               gp;
    logic [3:0][7:0]           duty;
    logic [31:0]               tick_cnt;
    logic                      tick;
    logic [7:0]                pwm_cnt;
    logic [NCH-1:0]            busy;
    logic [NCH-1:0]            search;
    logic [NCH-1:0]            ccw;
    logic [NCH-1:0]            pdir;
    logic [NCH-1:0]            origin_def;
    logic [NCH-1:0]            lim_stop;
    logic [NCH-1:0][FW-1:0]    tgt;
    logic [NCH-1:0][FW-1:0]    fcur;
    logic [NCH-1:0][ACCW-1:0]  acc;
    logic [NCH-1:0]            lvl;
    logic [NCH-1:0][31:0]      pos;
    logic [5:0]                out0;
    logic [5:0]                out1;
    pol_wb_rsp_type            rsp;
  } pol_state_type;

  pol_state_type state;
  pol_state_type next_state;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] pol_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : pol_merge

  // One control-cycle step of the frequency ramp
  function automatic logic [FW-1:0] pol_ramp(input logic [FW-1:0] cur,
                                             input logic [FW-1:0] tgt,
                                             input logic [15:0]   accel,
                                             input logic          s_curve);
    logic [FW-1:0] diff;
    logic [FW-1:0] step;
    diff = (cur < tgt) ? tgt - cur : cur - tgt;
    step = {1'b0, accel};
    if (s_curve) begin
      // Soft entry and exit: step grows from low speed, shrinks near target
      if (step > (cur >> 2) + 17'h00001) begin
        step = (cur >> 2) + 17'h00001;
      end
      if (step > (diff >> 2) + 17'h00001) begin
        step = (diff >> 2) + 17'h00001;
      end
    end
    if (step > diff) begin
      step = diff;
    end
    return (cur < tgt) ? cur + step : cur - step;
  endfunction : pol_ramp

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic        req_new;
  logic [1:0]  ch_sel;
  logic        ch_hit;
  logic [31:0] rd_data;

  assign req_new = wb_req.cyc & wb_req.stb & ~state.rsp.ack;
  assign ch_sel  = wb_req.adr[4:3];
  assign ch_hit  = (wb_req.adr[7:5] == REG_CH_REGION);

  always_comb begin
    rd_data = 32'h00000000;
    if (ch_hit) begin
      if (wb_req.adr[2]) begin
        rd_data = state.pos[ch_sel];
      end else begin
        rd_data[0] = state.busy[ch_sel];
        rd_data[1] = state.search[ch_sel];
        rd_data[2] = state.origin_def[ch_sel];
        rd_data[3] = state.lim_stop[ch_sel];
        rd_data[4] = state.ccw[ch_sel];
        rd_data[5] = state.pdir[ch_sel];
        rd_data[FREQ_LSB +: FW] = state.fcur[ch_sel];
      end
    end else begin
      case (wb_req.adr)
        REG_SETUP_PEND: rd_data[10:0] = state.pend_cfg;
        REG_SETUP_ACT:  rd_data[10:0] = state.act_cfg;
        REG_SPEED_PEND: rd_data[FW-1:0] = state.pend_speed;
        REG_SPEED_ACT:  rd_data[FW-1:0] = state.act_speed;
        REG_ACCEL:      rd_data[15:0] = state.accel;
        REG_GPOUT:      rd_data[11:0] = state.gp;
        REG_PWM_DUTY:   rd_data = state.duty;
        default:        rd_data = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0]       wv;
    logic [FW-1:0]     cmd_f;
    logic              lim_in;
    logic              lim_act;
    logic [ACCW-1:0]   sum;
    logic [NCH-1:0]    wr_cmd;
    wv     = 32'h00000000;
    cmd_f  = '0;
    lim_in = 1'b0;
    lim_act = 1'b0;
    sum    = '0;
    wr_cmd = '0;
    next_state = state;

    // Bus slave: one wait state, unmapped reads give zero
    next_state.rsp.ack = req_new;
    next_state.rsp.dat = req_new ? rd_data : 32'h00000000;

    if (req_new && wb_req.we) begin
      if (ch_hit) begin
        wr_cmd[ch_sel] = ~wb_req.adr[2];
      end else begin
        case (wb_req.adr)
          REG_SETUP_PEND: begin
            wv = pol_merge({21'h000000, state.pend_cfg}, wb_req.dat, wb_req.sel);
            next_state.pend_cfg = wv[10:0];
          end
          REG_SPEED_PEND: begin
            wv = pol_merge({15'h0000, state.pend_speed}, wb_req.dat, wb_req.sel);
            next_state.pend_speed = wv[FW-1:0];
          end
          REG_ACCEL: begin
            wv = pol_merge({16'h0000, state.accel}, wb_req.dat, wb_req.sel);
            next_state.accel = wv[15:0];
          end
          REG_GPOUT: begin
            wv = pol_merge({20'h00000, state.gp}, wb_req.dat, wb_req.sel);
            next_state.gp = wv[11:0];
          end
          REG_PWM_DUTY: next_state.duty = pol_merge(state.duty, wb_req.dat, wb_req.sel);
          default: ;
        endcase
      end
    end

    // Pending setup is adopted only at power-up or a restart
    if (state.adopt || power_restart) begin
      next_state.act_cfg   = state.pend_cfg;
      next_state.act_speed = state.pend_speed;
    end
    next_state.adopt = 1'b0;

    // Control cycle divider
    next_state.tick = 1'b0;
    if (state.tick_cnt == 32'h00000000) begin
      next_state.tick_cnt = state.act_cfg.cycle_1ms ? 32'(TICK_1MS_CYCLES - 1)
                                                    : 32'(TICK_4MS_CYCLES - 1);
      next_state.tick = 1'b1;
    end else begin
      next_state.tick_cnt = state.tick_cnt - 32'h00000001;
    end

    next_state.pwm_cnt = state.pwm_cnt + 8'h01;

    for (int c = 0; c < NCH; c++) begin
      // Frequency ramp on each control cycle
      if (state.tick && state.busy[c]) begin
        next_state.fcur[c] = pol_ramp(state.fcur[c], state.tgt[c], state.accel,
                                      state.act_cfg.s_curve);
        if (state.tgt[c] == '0 && state.fcur[c] == '0 && !state.search[c]) begin
          next_state.busy[c] = 1'b0;
        end
      end

      // Pulse train: level toggles at twice the output rate
      if (state.busy[c]) begin
        sum = state.acc[c] + ACCW'(state.fcur[c]);
        if (sum >= ACCW'(HALF_PERIOD_ACC)) begin
          next_state.acc[c] = sum - ACCW'(HALF_PERIOD_ACC);
          next_state.lvl[c] = ~state.lvl[c];
          if (!state.lvl[c]) begin
            next_state.pos[c] = state.ccw[c] ? state.pos[c] - 32'h00000001
                                             : state.pos[c] + 32'h00000001;
          end
        end else begin
          next_state.acc[c] = sum;
        end
      end else begin
        next_state.acc[c] = '0;
        next_state.lvl[c] = 1'b0;
      end

      // Origin found ends the search
      if (state.search[c] && sense.origin[c]) begin
        next_state.busy[c]       = 1'b0;
        next_state.search[c]     = 1'b0;
        next_state.fcur[c]       = '0;
        next_state.origin_def[c] = 1'b1;
        next_state.pos[c]        = 32'h00000000;
      end

      // Limit in the direction of travel
      lim_in  = state.ccw[c] ? sense.ccw[c] : sense.cw[c];
      lim_act = state.act_cfg.lim_no ? lim_in : ~lim_in;
      if (state.busy[c] && lim_act &&
          (state.search[c] || state.act_cfg.lim_always)) begin
        next_state.busy[c]     = 1'b0;
        next_state.search[c]   = 1'b0;
        next_state.fcur[c]     = '0;
        next_state.lim_stop[c] = 1'b1;
        if (state.act_cfg.clr_origin) begin
          next_state.origin_def[c] = 1'b0;
        end
      end

      // Commands
      if (wr_cmd[c]) begin
        cmd_f = wb_req.dat[FREQ_LSB +: FW];
        if (wb_req.dat[CMD_STOP]) begin
          next_state.tgt[c] = '0;
        end else if (wb_req.dat[CMD_SEARCH] && !state.busy[c]) begin
          next_state.busy[c]     = 1'b1;
          next_state.search[c]   = 1'b1;
          next_state.lim_stop[c] = 1'b0;
          next_state.ccw[c]      = wb_req.dat[CMD_CCW];
          next_state.pdir[c]     = wb_req.dat[CMD_PDIR];
          next_state.fcur[c]     = state.act_speed;
          next_state.tgt[c]      = cmd_f;
        end else if (wb_req.dat[CMD_START]) begin
          // A running channel only takes a new target speed
          next_state.tgt[c] = cmd_f;
          if (!state.busy[c]) begin
            next_state.busy[c]     = 1'b1;
            next_state.lim_stop[c] = 1'b0;
            next_state.ccw[c]      = wb_req.dat[CMD_CCW];
            next_state.pdir[c]     = wb_req.dat[CMD_PDIR];
            next_state.fcur[c]     = '0;
          end
        end
      end
    end

    // Terminal sharing per module
    for (int m = 0; m < 2; m++) begin
      logic [5:0] t;
      int         a;
      int         b;
      a = 2 * m;
      b = 2 * m + 1;
      t = state.gp[m*6 +: 6];
      if (state.act_cfg.pulse_en[m]) begin
        if (state.pdir[a]) begin
          t[0] = state.lvl[a];
          t[1] = state.lvl[b];
          t[2] = state.ccw[a];
          t[3] = state.ccw[b];
        end else begin
          t[0] = state.lvl[a] & ~state.ccw[a];
          t[1] = state.lvl[a] & state.ccw[a];
          t[2] = state.lvl[b] & ~state.ccw[b];
          t[3] = state.lvl[b] & state.ccw[b];
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (state.act_cfg.pwm_en[m*2+k]) begin
          t[4+k] = state.pwm_cnt < state.duty[m*2+k];
        end
      end
      if (m == 0) begin
        next_state.out0 = t;
      end else begin
        next_state.out1 = t;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= '0;
      state.pend_cfg <= CFG_RESET;
      state.act_cfg  <= CFG_RESET;
      state.accel    <= ACCEL_RESET;
      state.adopt    <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign wb_rsp            = state.rsp;
  assign module0_terminals = state.out0;
  assign module1_terminals = state.out1;

endmodule : pol_pulse_out

// [pol_motor_model.sv]
// Motor driver model with limit switches on channel 0
`timescale 1ns/100ps
module pol_motor_model #(
  parameter int LIM_POS = 4
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              nc,
  input  wire logic              home,
  input  wire logic [5:0]        terminals,
  output pol_pkg::pol_sense_type sense,
  output logic                   at_lim
);
  import pol_pkg::*;
  // ---------------------------------------------------------------
  // Axis position from CW and CCW trains
  // ---------------------------------------------------------------
  int         pos;
  logic [1:0] last;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos  <= 0;
      last <= 2'h0;
    end else begin
      last <= terminals[1:0];
      if (home) begin
        pos <= 0;
      end else if (terminals[0] && !last[0]) begin
        pos <= pos + 1;
      end else if (terminals[1] && !last[1]) begin
        pos <= pos - 1;
      end
    end
  end
  assign at_lim = pos >= LIM_POS;
  // ---------------------------------------------------------------
  // Contacts: 1 = closed; switch stays tripped past the limit
  // ---------------------------------------------------------------
  always_comb begin
    sense.cw     = {4{nc}};
    sense.ccw    = {4{nc}};
    sense.origin = {3'h0, home};
    sense.cw[0]  = nc ^ at_lim;
    sense.ccw[0] = nc ^ (pos <= -LIM_POS);
  end
endmodule : pol_motor_model

// [pol_pulse_out_assertions.sv]
// Checker for bus answers, setup adoption and terminal sharing
`timescale 1ns/100ps
module pol_pulse_out_checker
  import pol_pkg::*;
(
  input wire logic           mclk,
  input wire logic           rst_n,
  input wire logic           power_restart,
  input wire pol_wb_req_type wb_req,
  input wire pol_wb_rsp_type wb_rsp,
  input wire pol_sense_type  sense,
  input wire logic [5:0]     module0_terminals,
  input wire logic [5:0]     module1_terminals
);
  // ---------------------------------------------------------------
  // Shadows; sel ignored, full words assumed
  // ---------------------------------------------------------------
  logic        tk;
  logic        rd_act;
  logic [10:0] pend;
  logic [10:0] act;
  logic [11:0] gp;
  assign tk = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_act <= 1'h0;
      pend   <= 11'h000;
      act    <= 11'h000;
      gp     <= 12'h000;
    end else begin
      rd_act <= tk && !wb_req.we && wb_req.adr[7:2] == 6'h01;
      if (tk && wb_req.we && wb_req.adr[7:2] == 6'h00) pend <= wb_req.dat[10:0];
      if (tk && wb_req.we && wb_req.adr[7:2] == 6'h05) gp <= wb_req.dat[11:0];
      if (power_restart) act <= pend;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_ack_answer; tk |=> wb_rsp.ack; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
  property p_ack_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; wb_rsp.ack |-> $past(tk); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_rsp.ack |-> wb_rsp.dat == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_act_read; rd_act |-> wb_rsp.dat[10:0] == act; endproperty
  a_act_read: assert property (p_act_read) else $error("active setup wrong");
  property p_gp_m0;
    !act[5] && $stable(gp) && $stable(act) |-> module0_terminals[3:0] == gp[3:0];
  endproperty
  a_gp_m0: assert property (p_gp_m0) else $error("module0 general outputs wrong");
  property p_gp_m1;
    !act[6] && $stable(gp) && $stable(act) |-> module1_terminals[3:0] == gp[9:6];
  endproperty
  a_gp_m1: assert property (p_gp_m1) else $error("module1 general outputs wrong");
  property p_pwm_off;
    act[10:7] == 4'h0 && $stable(gp) && $stable(act)
      |-> {module1_terminals[5:4], module0_terminals[5:4]} == {gp[11:10], gp[5:4]};
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("shared outputs wrong");
endmodule : pol_pulse_out_checker

bind pol_pulse_out pol_pulse_out_checker u_chk (.mclk(mclk), .rst_n(rst_n),
  .power_restart(power_restart), .wb_req(wb_req), .wb_rsp(wb_rsp), .sense(sense),
  .module0_terminals(module0_terminals), .module1_terminals(module1_terminals));

// [testbench.sv]
// Self-checking bench for the pulse output block
`timescale 1ns/100ps
module testbench;
  import pol_pkg::*;
  logic           mclk;
  logic           rst_n;
  logic           power_restart;
  logic           nc;
  logic           home;
  logic           at_lim;
  pol_wb_req_type wb_req;
  pol_wb_rsp_type wb_rsp;
  pol_sense_type  sense;
  logic [5:0]     m0_term;
  logic [5:0]     m1_term;
  logic [31:0]    rdat;
  logic [31:0]    act_cfg;
  int             error_cnt;
  int             samples_checked;
  logic [16:0]    rise;
  // Short ticks keep ramps fast
  pol_pulse_out #(.TICK_4MS_CYCLES(40), .TICK_1MS_CYCLES(10)) uut (.mclk(mclk), .rst_n(rst_n),
    .power_restart(power_restart), .wb_req(wb_req), .wb_rsp(wb_rsp), .sense(sense),
    .module0_terminals(m0_term), .module1_terminals(m1_term));
  pol_motor_model #(.LIM_POS(4)) drv (.mclk(mclk), .rst_n(rst_n), .nc(nc), .home(home),
    .terminals(m0_term), .sense(sense), .at_lim(at_lim));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge mclk) wb_req <= '{cyc:1'h1, stb:1'h1, we:we, adr:adr, sel:4'hF, dat:dat};
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (wb_rsp.ack === 1'h1) break;
    end
    rdat = wb_rsp.dat;
    wb_req <= '0;
    if (n == 50) begin
      error_cnt++;
      final_report();
    end
  endtask : wb
  task wait_stat(input int idx, input logic val);
    int n;
    for (n = 0; n < 5000; n++) begin
      wb(1'h0, 8'h20, 32'h0);
      if (rdat[idx] === val) break;
    end
    if (n == 5000) begin
      error_cnt++;
      final_report();
    end
  endtask : wait_stat
  task restart_cfg(input logic [31:0] cfg);
    wb(1'h1, 8'h00, cfg);
    wb(1'h0, 8'h04, 32'h0);
    check(rdat, act_cfg);
    @(posedge mclk) power_restart <= 1'h1;
    @(posedge mclk) power_restart <= 1'h0;
    act_cfg = cfg;
    wb(1'h0, 8'h04, 32'h0);
    check(rdat, cfg);
  endtask : restart_cfg
  task pulse_home;
    @(posedge mclk) home <= 1'h1;
    @(posedge mclk) home <= 1'h0;
  endtask : pulse_home
  // Home first so a tripped switch cannot abort the search
  task do_search;
    pulse_home();
    // Target equal to the initial speed, so a tick cannot move it before the read
    wb(1'h1, 8'h20, 32'h003E8004);
    wb(1'h0, 8'h20, 32'h0);
    check(rdat & 32'h1FFFF002, 32'h003E8002);
    pulse_home();
    wait_stat(2, 1'h1);
    check(rdat & 32'h7, 32'h4);
  endtask : do_search
  task run_to_limit(input logic [31:0] exp);
    wb(1'h1, 8'h20, 32'h186A0001);
    wait_stat(3, 1'h1);
    check(rdat & 32'hF, exp);
  endtask : run_to_limit
  // Speed gain across 40 cycles between two taken reads: whole ticks only
  task ramp_rise(input logic [31:0] cmd);
    logic [16:0] f0;
    wb(1'h1, 8'h20, cmd);
    wb(1'h0, 8'h20, 32'h0);
    f0 = rdat[28:12];
    repeat (37) @(posedge mclk);
    wb(1'h0, 8'h20, 32'h0);
    rise = rdat[28:12] - f0;
  endtask : ramp_rise
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    rst_n = 1'h0;
    power_restart = 1'h0;
    wb_req = '0;
    nc = 1'h1;
    home = 1'h0;
    act_cfg = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    wb(1'h0, 8'h10, 32'h0);
    check(rdat, 32'h1);
    wb(1'h0, 8'h0C, 32'h0);
    check(rdat, 32'h0);
    wb(1'h0, 8'hFC, 32'h0);
    check(rdat, 32'h0);
    $display("test reset values done");
    wb(1'h1, 8'h08, 32'h3E8);
    wb(1'h1, 8'h10, 32'hFFFF);
    wb(1'h1, 8'h14, 32'hFFF);
    restart_cfg(32'h781);
    wb(1'h0, 8'h0C, 32'h0);
    check(rdat, 32'h3E8);
    check(32'(m0_term), 32'hF);
    check(32'(m1_term), 32'hF);
    $display("test setup adoption done");
    restart_cfg(32'h7A1);
    check(32'(m0_term), 32'h0);
    do_search();
    wb(1'h1, 8'h20, 32'h186A0001);
    for (n = 0; n < 20000 && !at_lim; n++) @(posedge mclk);
    if (n == 20000) begin
      error_cnt++;
      final_report();
    end
    repeat (20) @(posedge mclk);
    wb(1'h0, 8'h20, 32'h0);
    check(rdat & 32'h9, 32'h1);
    wb(1'h1, 8'h20, 32'h2);
    wait_stat(0, 1'h0);
    $display("test search only done");
    restart_cfg(32'h7A3);
    do_search();
    run_to_limit(32'hC);
    $display("test hold origin done");
    nc <= 1'h0;
    restart_cfg(32'h7AF);
    do_search();
    run_to_limit(32'h8);
    $display("test clear origin done");
    // Slow CCW runs: no pulses reach the switches, so no limit interferes
    wb(1'h1, 8'h10, 32'h5);
    ramp_rise(32'h003E8009);
    check(32'(rise), 32'h14);
    wb(1'h1, 8'h20, 32'h2);
    wait_stat(0, 1'h0);
    restart_cfg(32'h7BF);
    ramp_rise(32'h003E8019);
    check(32'(rise < 17'h00008), 32'h1);
    check(32'(m0_term), 32'h4);
    wb(1'h1, 8'h20, 32'h2);
    wait_stat(0, 1'h0);
    $display("test ramp and tick done");
    final_report();
  end
endmodule : testbench
